// ### nvm_access_defs.svh
`ifndef NVM_ACCESS_DEFS_SVH
`define NVM_ACCESS_DEFS_SVH

// -----------------------------------------------------------------------------
// I/O addresses and data-space alias.
// -----------------------------------------------------------------------------
`define IO_ADDR_CONTROL   6'h1F
`define IO_ADDR_DATA      6'h20
`define IO_ADDR_ADDR_LOW  6'h21
`define IO_ADDR_ADDR_HIGH 6'h22
`define IO_DATA_OFFSET    8'h20
`define IO_BIT_OPS_TOP    6'h1F

// -----------------------------------------------------------------------------
// Control register bit positions.
// -----------------------------------------------------------------------------
`define CTL_READ_STROBE   0
`define CTL_WRITE_STROBE  1
`define CTL_MASTER_WE     2
`define CTL_READY_IE      3
`define CTL_MODE_LO       4
`define CTL_MODE_HI       5

// -----------------------------------------------------------------------------
// Reset values and sizes.
// -----------------------------------------------------------------------------
`define MODE_RESET        2'h0
`define NVM_DEPTH         1024

// -----------------------------------------------------------------------------
// Timing: times in microseconds, cycles at a 100 MHz clock.
// -----------------------------------------------------------------------------
`define CLK_MHZ           100
`define TIME_ERASE_WRITE_US 3400
`define TIME_SINGLE_US    1800
`define CYC_ERASE_WRITE   (`TIME_ERASE_WRITE_US * `CLK_MHZ)
`define CYC_SINGLE        (`TIME_SINGLE_US * `CLK_MHZ)
`define CYC_READ_STALL    4
`define CYC_WRITE_STALL   2
`define CYC_MASTER_WE     4

`endif

// ### nvm_access_pkg.sv
package nvm_access_pkg;

  // Programming mode field encodings.
  typedef enum logic [1:0] {
    MODE_ERASE_WRITE = 2'b00,
    MODE_ERASE_ONLY  = 2'b01,
    MODE_WRITE_ONLY  = 2'b10,
    MODE_RESERVED    = 2'b11
  } prog_mode_type;

  // Programming sequencer states.
  typedef enum logic [1:0] {
    PROG_IDLE   = 2'b00,
    PROG_BUSY   = 2'b01,
    PROG_COMMIT = 2'b10
  } prog_state_type;

endpackage

// ### nvm_store.sv
`timescale 1ns/10ps
`include "nvm_access_defs.svh"

// -----------------------------------------------------------------------------
// Byte-wide nonvolatile array with combinational read and clocked update.
// -----------------------------------------------------------------------------
module nvm_store (
  input  wire logic       clk,
  input  wire logic [9:0] addr,
  input  wire logic       eraseEn,
  input  wire logic       writeEn,
  input  wire logic [7:0] wrData,
  output logic      [7:0] rdData
);

  // Storage cells; an erased byte reads as all ones.
  logic [7:0] cells [0:`NVM_DEPTH-1];

  // Read port is immediate so a read strobe returns data at once.
  always_comb begin
    rdData = cells[addr];
  end

  // Erase sets bits, write clears bits, both together store the byte.
  always_ff @(posedge clk) begin
    if (eraseEn && writeEn) begin
      cells[addr] <= wrData;
    end else if (eraseEn) begin
      cells[addr] <= 8'hFF;
    end else if (writeEn) begin
      cells[addr] <= cells[addr] & wrData;
    end
  end

endmodule

// ### nvm_access_ctrl.sv
`timescale 1ns/10ps
`include "nvm_access_defs.svh"

// Contract
// RULE1: Separate byte-wide nonvolatile data space.
// RULE2: Read stalls core four cycles.
// RULE3: Write stalls core two cycles.
// RULE4: Self-timed programming with readable completion.
// RULE5: Reset does not abort programming.
// RULE6: Unlock sequence required before programming.
// RULE7: Ten-bit linear address split high/low.
// RULE8: Address undefined at reset; software loads.
// RULE9: Small variant: write upper address zero.
// RULE10: Reserved bits read as zero.
// RULE11: Write programs data byte at address.
// RULE12: Read loads addressed byte into data.
// RULE13: Mode field decode and durations.
// RULE14: Mode selects launched programming action.
// RULE15: Mode writes ignored while strobe set.
// RULE16: Reset clears mode unless busy.
// RULE17: Bit set/clear touches only one bit.
// RULE18: Registers aliased at I/O address plus 0x20.
// RULE19: Master enable self-clears after four cycles.
// RULE20: Write strobe self-clears when done.
// RULE21: Immediate read; writes block reads, address.
// RULE22: Ready interrupt while strobe clear.
// RULE23: Reserved mode clears strobe, no programming.
module nvm_access_ctrl
  import nvm_access_pkg::*;
#(
  parameter int unsigned CYC_ERASE_WRITE = `CYC_ERASE_WRITE,
  parameter int unsigned CYC_SINGLE      = `CYC_SINGLE
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ioWrite,
  input  wire logic       ioRead,
  input  wire logic       dataSpace,
  input  wire logic [7:0] ioAddr,
  input  wire logic [7:0] ioWrData,
  input  wire logic       bitSet,
  input  wire logic       bitClear,
  input  wire logic [2:0] bitIndex,
  input  wire logic       globalIrqEnable,
  output logic      [7:0] ioRdData,
  output logic            coreStall,
  output logic            readyIrq
);

  // ---------------------------------------------------------------------------
  // Register state.
  // ---------------------------------------------------------------------------
  logic [9:0]     addr_reg, addr_next;             // Byte address.
  logic [7:0]     data_reg, data_next;             // Data byte.
  prog_mode_type  mode_reg, mode_next;             // Programming mode field.
  logic           irqEn_reg, irqEn_next;           // Ready interrupt enable.
  logic           mwe_reg, mwe_next;               // Master write enable.
  logic [2:0]     mweCnt_reg, mweCnt_next;         // Master enable timer.
  logic           strobe_reg, strobe_next;         // Write strobe, busy flag.
  prog_state_type state_reg, state_next;           // Programming sequencer.
  logic [18:0]    progCnt_reg, progCnt_next;       // Programming timer.
  logic [2:0]     stallCnt_reg, stallCnt_next;     // Core stall timer.
  logic [7:0]     rdData_reg, rdData_next;         // Registered read data.
  logic           irq_reg, irq_next;               // Registered interrupt.
  logic           stall_reg, stall_next;           // Registered core stall.
  logic           eraseEn, writeEn;                // Array update strobes.
  logic [7:0]     storeData;                       // Array read data.

  // Decoded access.
  logic [5:0] ioIdx;
  logic       anyWrite;
  logic [7:0] ctlNow;
  logic [7:0] ctlWr;
  logic [7:0] wrVal;

  // ---------------------------------------------------------------------------
  // Helper functions.
  // ---------------------------------------------------------------------------

  // Maps a data-space address back to its I/O index, or passes I/O through.
  function automatic logic [5:0] to_io_index(input logic [7:0] a, input logic ds);
    logic [7:0] t;
    t = ds ? (a - `IO_DATA_OFFSET) : a; // RULE18
    // Anything outside the 64-entry I/O window maps to an unused index.
    return (t[7:6] == 2'b00) ? t[5:0] : 6'h3F;
  endfunction

  // Returns the programming time for a mode, zero for the reserved code.
  function automatic logic [18:0] prog_cycles(input prog_mode_type m);
    logic [18:0] c;
    c = 19'h0;
    case (m)
      MODE_ERASE_WRITE: c = CYC_ERASE_WRITE[18:0]; // RULE13
      MODE_ERASE_ONLY:  c = CYC_SINGLE[18:0];
      MODE_WRITE_ONLY:  c = CYC_SINGLE[18:0];
      default:          c = 19'h0;
    endcase
    return c;
  endfunction

  // Applies a byte write or a single-bit set/clear to a current value.
  function automatic logic [7:0] merge_write(input logic [7:0] cur, input logic [7:0] d,
                                             input logic s, input logic c,
                                             input logic [2:0] i);
    logic [7:0] r;
    r = d;
    if (s) begin
      r = cur | (8'h01 << i); // RULE17
    end else if (c) begin
      r = cur & ~(8'h01 << i); // RULE17
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // Nonvolatile array.
  // ---------------------------------------------------------------------------
  nvm_store u_store (
    .clk     (clk),
    .addr    (addr_reg),
    .eraseEn (eraseEn),
    .writeEn (writeEn),
    .wrData  (data_reg),
    .rdData  (storeData)
  ); // RULE1

  // ---------------------------------------------------------------------------
  // Access decode.
  // ---------------------------------------------------------------------------

  // Bit operations reach only the low I/O registers and never the data space.
  always_comb begin
    ioIdx    = to_io_index(ioAddr, dataSpace);
    anyWrite = ioWrite || ((bitSet || bitClear) && !dataSpace &&
                           (ioAddr[5:0] <= `IO_BIT_OPS_TOP) && (ioAddr[7:6] == 2'b00));
    ctlNow   = {2'b00, mode_reg, irqEn_reg, mwe_reg, strobe_reg, 1'b0};
    ctlWr    = merge_write(ctlNow, ioWrData, bitSet && !ioWrite, bitClear && !ioWrite,
                           bitIndex);
    wrVal    = ioWrData;
  end

  // ---------------------------------------------------------------------------
  // Register and sequencer next-state logic.
  // ---------------------------------------------------------------------------
  always_comb begin
    addr_next     = addr_reg;
    data_next     = data_reg;
    mode_next     = mode_reg;
    irqEn_next    = irqEn_reg;
    mwe_next      = mwe_reg;
    mweCnt_next   = mweCnt_reg;
    strobe_next   = strobe_reg;
    state_next    = state_reg;
    progCnt_next  = progCnt_reg;
    stallCnt_next = (stallCnt_reg != 3'h0) ? stallCnt_reg - 3'h1 : 3'h0;
    eraseEn       = 1'b0;
    writeEn       = 1'b0;

    // Master enable times out four cycles after being set.
    if (mwe_reg) begin
      if (mweCnt_reg == 3'h1) begin
        mwe_next    = 1'b0; // RULE19
        mweCnt_next = 3'h0;
      end else begin
        mweCnt_next = mweCnt_reg - 3'h1;
      end
    end

    // Programming sequencer runs regardless of core resets.
    case (state_reg)
      PROG_IDLE: begin
      end
      PROG_BUSY: begin
        if (progCnt_reg <= 19'h1) begin
          state_next = PROG_COMMIT; // RULE4
        end else begin
          progCnt_next = progCnt_reg - 19'h1;
        end
      end
      PROG_COMMIT: begin
        eraseEn     = (mode_reg == MODE_ERASE_WRITE) || (mode_reg == MODE_ERASE_ONLY); // RULE14
        writeEn     = (mode_reg == MODE_ERASE_WRITE) || (mode_reg == MODE_WRITE_ONLY); // RULE11
        strobe_next = 1'b0; // RULE20
        state_next  = PROG_IDLE;
      end
      default: begin
        state_next = PROG_IDLE;
      end
    endcase

    // Register writes.
    if (anyWrite) begin
      if (ioIdx == `IO_ADDR_CONTROL) begin
        irqEn_next = ctlWr[`CTL_READY_IE];
        if (!strobe_reg) begin
          mode_next = prog_mode_type'(ctlWr[`CTL_MODE_HI:`CTL_MODE_LO]); // RULE15
        end
        if (ctlWr[`CTL_MASTER_WE] && !mwe_reg) begin
          mwe_next    = 1'b1;
          mweCnt_next = 3'(`CYC_MASTER_WE);
        end else if (!ctlWr[`CTL_MASTER_WE]) begin
          mwe_next = 1'b0;
        end
        // Strobe takes effect only inside the unlock window and when idle.
        if (ctlWr[`CTL_WRITE_STROBE] && mwe_reg && !strobe_reg) begin // RULE6
          strobe_next   = 1'b1;
          mwe_next      = 1'b0;
          stallCnt_next = 3'(`CYC_WRITE_STALL); // RULE3
          if (prog_cycles(mode_next) == 19'h0) begin
            state_next = PROG_IDLE; // RULE23
            strobe_next = 1'b0;
          end else begin
            state_next   = PROG_BUSY;
            progCnt_next = prog_cycles(mode_next);
          end
        end
        // Read strobe fetches at once, but not while programming.
        if (ctlWr[`CTL_READ_STROBE] && !strobe_reg) begin // RULE21
          data_next     = storeData; // RULE12
          stallCnt_next = 3'(`CYC_READ_STALL); // RULE2
        end
      end else if (ioIdx == `IO_ADDR_DATA) begin
        data_next = wrVal;
      end else if (ioIdx == `IO_ADDR_ADDR_LOW && !strobe_reg) begin
        addr_next[7:0] = wrVal; // RULE7
      end else if (ioIdx == `IO_ADDR_ADDR_HIGH && !strobe_reg) begin
        addr_next[9:8] = wrVal[1:0]; // RULE7
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read data and interrupt next values.
  // ---------------------------------------------------------------------------
  always_comb begin
    rdData_next = 8'h00;
    if (ioRead) begin
      if (ioIdx == `IO_ADDR_CONTROL) begin
        rdData_next = {2'b00, mode_reg, irqEn_reg, mwe_reg, strobe_reg, 1'b0}; // RULE10
      end else if (ioIdx == `IO_ADDR_DATA) begin
        rdData_next = data_reg;
      end else if (ioIdx == `IO_ADDR_ADDR_LOW) begin
        rdData_next = addr_reg[7:0];
      end else if (ioIdx == `IO_ADDR_ADDR_HIGH) begin
        rdData_next = {6'h00, addr_reg[9:8]}; // RULE10
      end
    end
    irq_next = irqEn_reg && globalIrqEnable && !strobe_next; // RULE22
    stall_next = (stallCnt_next != 3'h0); // RULE2 RULE3
  end

  // ---------------------------------------------------------------------------
  // State registers.
  // ---------------------------------------------------------------------------

  // Address and data have no reset value; software must load them.
  always_ff @(posedge clk) begin
    addr_reg <= addr_next; // RULE8
    data_reg <= data_next;
  end

  // Programming state survives reset so an operation in flight completes.
  always_ff @(posedge clk) begin
    if (!rst_n && (state_reg == PROG_BUSY || state_reg == PROG_COMMIT)) begin
      mode_reg    <= mode_reg; // RULE5
      strobe_reg  <= strobe_next;
      state_reg   <= state_next;
      progCnt_reg <= progCnt_next;
    end else if (!rst_n) begin
      // An idle or unknown power-up sequencer is cleared here.
      mode_reg    <= prog_mode_type'(`MODE_RESET); // RULE16
      strobe_reg  <= 1'b0;
      state_reg   <= PROG_IDLE;
      progCnt_reg <= 19'h0;
    end else begin
      mode_reg    <= mode_next;
      strobe_reg  <= strobe_next;
      state_reg   <= state_next;
      progCnt_reg <= progCnt_next;
    end
  end

  // Core-facing control and outputs reset normally.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqEn_reg    <= 1'b0;
      mwe_reg      <= 1'b0;
      mweCnt_reg   <= 3'h0;
      stallCnt_reg <= 3'h0;
      rdData_reg   <= 8'h00;
      irq_reg      <= 1'b0;
      stall_reg    <= 1'b0;
    end else begin
      irqEn_reg    <= irqEn_next;
      mwe_reg      <= mwe_next;
      mweCnt_reg   <= mweCnt_next;
      stallCnt_reg <= stallCnt_next;
      rdData_reg   <= rdData_next;
      irq_reg      <= irq_next;
      stall_reg    <= stall_next;
    end
  end

  // Outputs straight from flip-flops.
  always_comb begin
    ioRdData  = rdData_reg;
    coreStall = stall_reg;
    readyIrq  = irq_reg;
  end

endmodule

// ### nvm_access_ctrl_props.sv
`timescale 1ns/10ps
// --------------------------------------
// Port checks of the access controller.
// --------------------------------------
module nvm_access_ctrl_props #(
  parameter int unsigned CYC_ERASE_WRITE = 20,
  parameter int unsigned CYC_SINGLE      = 10
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ioWrite,
  input wire logic       ioRead,
  input wire logic       dataSpace,
  input wire logic [7:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic       bitSet,
  input wire logic       bitClear,
  input wire logic [2:0] bitIndex,
  input wire logic       globalIrqEnable,
  input wire logic [7:0] ioRdData,
  input wire logic       coreStall,
  input wire logic       readyIrq
);
  // Control hits in either space; kick is any request that may raise the strobe.
  wire ctlHit = (!dataSpace && ioAddr == 8'h1F) || (dataSpace && ioAddr == 8'h3F);
  wire ctlWr  = ioWrite && ctlHit;
  wire kick   = (ctlWr && ioWrData[1]) || (bitSet && ioAddr == 8'h1F && bitIndex == 3'h1);
  wire hiRd   = ioRead && ioAddr == (dataSpace ? 8'h42 : 8'h22);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Arm, then launch on the next edge while the strobe is idle.
  sequence s_unlock(logic [1:0] m);
    (ctlWr && ioWrData == {2'h0, m, 4'hC}) ##1
    (ctlWr && ioWrData == {2'h0, m, 4'hA} && readyIrq);
  endsequence
  a_read_stall: assert property (
    ctlWr && ioWrData == 8'h09 && readyIrq && !$past(kick) |=> coreStall [*4] ##1 !coreStall)
    else $error("read stall length wrong");
  a_write_stall: assert property (
    s_unlock(2'h0) |=> coreStall [*2] ##1 !coreStall) else $error("write stall length wrong");
  a_long_prog: assert property (
    s_unlock(2'h0) |-> ##2 !readyIrq [*8] ##[12:16] readyIrq) else $error("long program time wrong");
  a_short_prog: assert property (
    (s_unlock(2'h1) or s_unlock(2'h2)) |-> ##2 !readyIrq [*6] ##[4:8] readyIrq)
    else $error("short program time wrong");
  a_resv_mode: assert property (
    s_unlock(2'h3) |-> ##1 readyIrq [*4]) else $error("reserved mode launched");
  a_ctl_reserved: assert property (
    ioRead && ctlHit |=> ioRdData[7:6] == 2'h0 && !ioRdData[0]) else $error("control bits set");
  a_hi_reserved: assert property (
    hiRd |=> ioRdData[7:2] == 6'h00) else $error("address high bits set");
  a_irq_gate: assert property (
    !globalIrqEnable |=> !readyIrq) else $error("ready request without global enable");
endmodule

// ### core_model.sv
`timescale 1ns/10ps
// --------------------------------------
// Core side: tallies halted cycles.
// --------------------------------------
module core_model (
  input  wire logic clk,
  input  wire logic countClr,
  input  wire logic coreStall,
  output int        stallCount
);
  int stallReg;   // Halted cycles since the last clear.
  int stallNext;  // Next tally.
  // The core executes nothing while halted; each such cycle is counted.
  always_comb begin
    stallNext = stallReg;
    if (countClr) begin
      stallNext = 0;
    end else if (coreStall) begin
      stallNext = stallReg + 1;
    end
  end
  always_ff @(posedge clk) begin
    stallReg <= stallNext;
  end
  assign stallCount = stallReg;
endmodule

// ### tb_top.sv
`timescale 1ns/10ps
// --------------------------------------
// Bench for the access controller.
// --------------------------------------
module tb_top;
  import nvm_access_pkg::*;
  localparam int unsigned CYC_LONG  = 20;
  localparam int unsigned CYC_SHORT = 10;
  localparam logic [8:0]  CTL       = 9'h01F;
  localparam logic [8:0]  DAT       = 9'h020;
  logic       clk;
  logic       rst_n;
  logic       ioWrite;
  logic       ioRead;
  logic       dataSpace;
  logic [7:0] ioAddr;
  logic [7:0] ioWrData;
  logic       bitSet;
  logic       bitClear;
  logic [2:0] bitIndex;
  logic       globalIrqEnable;
  logic [7:0] ioRdData;
  logic       coreStall;
  logic       readyIrq;
  logic       countClr;
  int         stallCount;
  int         failures = 0;
  int         nChecks  = 0;
  int         cycles   = 0;
  logic [7:0] v;
  prog_mode_type md [5] = '{MODE_ERASE_ONLY, MODE_WRITE_ONLY, MODE_ERASE_WRITE,
                            MODE_RESERVED, MODE_WRITE_ONLY};
  logic [7:0] dt [5] = '{8'h00, 8'h5A, 8'hA5, 8'h00, 8'h0F};
  logic [7:0] ex [5] = '{8'hFF, 8'h5A, 8'hA5, 8'hA5, 8'h05};

  nvm_access_ctrl #(.CYC_ERASE_WRITE(CYC_LONG), .CYC_SINGLE(CYC_SHORT)) dut_u (
    .clk(clk), .rst_n(rst_n), .ioWrite(ioWrite), .ioRead(ioRead), .dataSpace(dataSpace),
    .ioAddr(ioAddr), .ioWrData(ioWrData), .bitSet(bitSet), .bitClear(bitClear),
    .bitIndex(bitIndex), .globalIrqEnable(globalIrqEnable), .ioRdData(ioRdData),
    .coreStall(coreStall), .readyIrq(readyIrq));
  core_model core_u (.clk(clk), .countClr(countClr), .coreStall(coreStall),
    .stallCount(stallCount));

  // Clock and a hang limit.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      test_done();
    end
  end

  // Compares one byte and counts it.
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    nChecks = nChecks + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  // Drives one request for the next edge; k is {write, read, set, clear}.
  task automatic put(input logic [3:0] k, input logic [2:0] i, input logic [8:0] a,
                     input logic [7:0] d);
    @(negedge clk);
    {ioWrite, ioRead, bitSet, bitClear} = k;
    bitIndex = i;
    dataSpace = a[8];
    ioAddr = a[7:0];
    ioWrData = d;
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    put(4'h8, 3'h0, a, d);
  endtask
  task automatic bop(input logic [3:0] k, input logic [2:0] i);
    put(k, i, CTL, 8'h00);
  endtask
  task automatic idle(input int n);
    repeat (n) put(4'h0, 3'h0, DAT, 8'h00);
  endtask
  // Read data is registered on the request edge and sampled at the falling edge that follows it.
  task automatic rd(input logic [8:0] a, output logic [7:0] q);
    put(4'h4, 3'h0, a, 8'h00);
    @(negedge clk);
    ioRead = 1'b0;
    q = ioRdData;
  endtask
  // Read strobe, then the data register.
  task automatic fetch(output logic [7:0] q);
    wr(CTL, 8'h09);
    rd(DAT, q);
  endtask
  // Data, arm, launch on back-to-back edges.
  task automatic prog(input prog_mode_type m, input logic [7:0] d);
    wr(DAT, d);
    wr(CTL, {2'h0, m, 4'hC});
    wr(CTL, {2'h0, m, 4'hA});
  endtask
  task automatic waitDone();
    logic [7:0] q;
    repeat (40) begin
      rd(CTL, q);
      if (q[1] === 1'b0) break;
    end
    chk8("strobeDone", 8'h00, q & 8'h02);
  endtask
  // Lets a stall still draining from the last access finish before clearing.
  task automatic clr();
    repeat (2) @(negedge clk);
    countClr = 1'b1;
    @(negedge clk);
    countClr = 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d, failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    {ioWrite, ioRead, bitSet, bitClear, dataSpace} = 5'h00;
    ioAddr = 8'h00;
    ioWrData = 8'h00;
    bitIndex = 3'h0;
    globalIrqEnable = 1'b1;
    countClr = 1'b0;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    rd(CTL, v);
    chk8("ctlReset", 8'h00, v);
    wr(9'h142, 8'hFF);
    rd(9'h022, v);
    chk8("addrHigh", 8'h03, v);
    wr(9'h023, 8'h5A);
    rd(9'h023, v);
    chk8("unmapped", 8'h00, v);
    wr(9'h141, 8'hFF);
    for (int i = 0; i < 5; i++) begin
      prog(md[i], dt[i]);
      waitDone();
      fetch(v);
      chk8("storeByte", ex[i], v);
    end
    clr();
    prog(MODE_ERASE_WRITE, 8'h3C);
    idle(3);
    chk8("writeStall", 8'h02, stallCount[7:0]);
    wr(CTL, 8'h38);
    wr(9'h021, 8'h00);
    rd(CTL, v);
    chk8("modeHold", 8'h0A, v);
    waitDone();
    rd(9'h021, v);
    chk8("addrLock", 8'hFF, v);
    clr();
    fetch(v);
    chk8("busyByte", 8'h3C, v);
    idle(3);
    chk8("readStall", 8'h04, stallCount[7:0]);
    wr(CTL, 8'h0C);
    rd(CTL, v);
    chk8("armed", 8'h0C, v);
    idle(2);
    wr(CTL, 8'h0A);
    rd(CTL, v);
    chk8("lateStrobe", 8'h08, v);
    wr(DAT, 8'h81);
    bop(4'h2, 3'h2);
    bop(4'h2, 3'h1);
    rd(CTL, v);
    chk8("bitLaunch", 8'h0A, v);
    waitDone();
    fetch(v);
    chk8("bitByte", 8'h81, v);
    bop(4'h1, 3'h3);
    rd(CTL, v);
    chk8("bitClear", 8'h00, v);
    chk8("irqOff", 8'h00, {7'h00, readyIrq});
    bop(4'h2, 3'h3);
    idle(2);
    chk8("irqOn", 8'h01, {7'h00, readyIrq});
    globalIrqEnable = 1'b0;
    idle(2);
    chk8("irqMask", 8'h00, {7'h00, readyIrq});
    globalIrqEnable = 1'b1;
    prog(MODE_ERASE_ONLY, 8'h00);
    waitDone();
    prog(MODE_WRITE_ONLY, 8'h66);
    idle(3);
    rst_n = 1'b0;
    idle(3);
    rst_n = 1'b1;
    rd(CTL, v);
    chk8("resetBusy", 8'h22, v);
    waitDone();
    fetch(v);
    chk8("resetByte", 8'h66, v);
    wr(9'h022, 8'h00);
    rd(9'h022, v);
    chk8("addrHighZero", 8'h00, v);
    test_done();
  end
endmodule

bind nvm_access_ctrl nvm_access_ctrl_props #(
  .CYC_ERASE_WRITE(CYC_ERASE_WRITE), .CYC_SINGLE(CYC_SINGLE)) props_u (
  .clk(clk), .rst_n(rst_n), .ioWrite(ioWrite), .ioRead(ioRead), .dataSpace(dataSpace),
  .ioAddr(ioAddr), .ioWrData(ioWrData), .bitSet(bitSet), .bitClear(bitClear),
  .bitIndex(bitIndex), .globalIrqEnable(globalIrqEnable), .ioRdData(ioRdData),
  .coreStall(coreStall), .readyIrq(readyIrq));
